// *** design/sensor_regs_pkg.sv ***
// Shared constants for the light-sensor host register set.
// Assumes one 20 MHz core clock and an I2C link sampled by that clock.
package sensor_regs_pkg;
  // ==========================================================
  // Register offsets (8-bit register pointer)
  localparam logic [7:0] OFS_PARAM_INBOX = 8'h17;  // Argument byte
  localparam logic [7:0] OFS_MAILBOX     = 8'h18;  // Command mailbox
  localparam logic [7:0] OFS_RESPONSE    = 8'h20;  // Response code
  localparam logic [7:0] OFS_FLAGS       = 8'h21;  // Pending event flags
  localparam logic [7:0] OFS_VIS_LOW     = 8'h22;  // Visible result low
  localparam logic [7:0] OFS_VIS_HIGH    = 8'h23;  // Visible result high
  localparam logic [7:0] OFS_IR_LOW      = 8'h24;  // Infrared result low
  localparam logic [7:0] OFS_IR_HIGH     = 8'h25;  // Infrared result high
  // ==========================================================
  // Reset values and field layout
  localparam logic [7:0] REG_RESET       = 8'h00;  // Every register
  localparam int         FLAG_BITS       = 6;      // Flags in bits 5:0
  localparam int         FLAG_CMD_POS    = 5;      // Command-completion
  localparam int         FLAG_PROX_POS   = 2;      // Channel one; two, three above
  localparam int         PROX_CHANNELS   = 3;      // Proximity channels
  localparam logic [1:0] PROX_MODE_KEEP  = 2'h3;   // Mode kept on auto clear
  localparam logic [3:0] COUNT_STEP      = 4'h1;   // Rolling counter step
  // ==========================================================
  // Command and response codes
  localparam logic [7:0] NO_OPERATION_CMD = 8'h00;
  localparam logic [7:0] CMD_RESET_CODE   = 8'h01;
  localparam logic [7:0] ERR_INVALID      = 8'h80;
  localparam logic [7:0] ERR_PROX_ONE     = 8'h88;
  localparam logic [7:0] ERR_PROX_TWO     = 8'h89;
  localparam logic [7:0] ERR_PROX_THREE   = 8'h8A;
  localparam logic [7:0] ERR_VISIBLE      = 8'h8C;
  localparam logic [7:0] ERR_INFRARED     = 8'h8D;
  localparam logic [7:0] ERR_AUX          = 8'h8E;
  // ==========================================================
  // Link constants
  localparam logic [6:0] LINK_DEV_ADDR   = 7'h2A;  // Arbitrary slave address
  localparam logic [3:0] BYTE_BITS       = 4'h8;   // Bits per byte
  localparam logic [3:0] BIT_ONE         = 4'h1;   // Bit counter step
endpackage : sensor_regs_pkg

// *** design/pin_sync.sv ***
// Two-flip-flop synchroniser for pins outside the core clock domain.
// Assumes the reader only looks at the second stage.
module pin_sync
  import sensor_regs_pkg::*;
#(
  parameter int WIDTH = 2
) (
  input  wire logic             core_clk_i,
  input  wire logic             arst_n_i,
  input  wire logic             clk_en_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] sync_o
);
  // ==========================================================
  // Stages
  logic [WIDTH-1:0] meta;  // First stage, read only by the second

  // Idle I2C lines are high, so both stages reset high
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      meta   <= '1;
      sync_o <= '1;
    end else if (clk_en_i) begin
      meta   <= pin_i;
      sync_o <= meta;
    end
  end
endmodule : pin_sync

// *** design/i2c_byte_link.sv ***
// Byte engine of the I2C slave: start/stop, address match, ack, shift.
// Assumes SCL and SDA arrive already synchronised to core_clk_i.
module i2c_byte_link
  import sensor_regs_pkg::*;
(
  input  wire logic       core_clk_i,
  input  wire logic       arst_n_i,
  input  wire logic       clk_en_i,
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  input  wire logic [7:0] rd_data_i,
  output logic            wr_stb_o,
  output logic            wr_first_o,
  output logic      [7:0] wr_data_o,
  output logic            rd_stb_o,
  output logic            sda_drive_o
);
  typedef enum logic [2:0] {
    ST_IDLE      = 3'b000,
    ST_ADDR      = 3'b001,
    ST_ADDR_ACK  = 3'b010,
    ST_WRITE     = 3'b011,
    ST_WRITE_ACK = 3'b100,
    ST_READ      = 3'b101,
    ST_READ_ACK  = 3'b110
  } link_state_type;

  link_state_type state;     // Transfer phase
  logic           scl_d;     // SCL one sample ago
  logic           sda_d;     // SDA one sample ago
  logic [7:0]     shift;     // Incoming bits
  logic [7:0]     tx;        // Outgoing bits
  logic [3:0]     bitcnt;    // Bits done in this byte
  logic           rw;        // Read transfer
  logic           first;     // Next write byte is the pointer
  logic           scl_rise;
  logic           scl_fall;
  logic           start_c;
  logic           stop_c;

  assign scl_rise = scl_i && !scl_d;
  assign scl_fall = !scl_i && scl_d;
  assign start_c  = scl_i && scl_d && sda_d && !sda_i;
  assign stop_c   = scl_i && scl_d && !sda_d && sda_i;

  // ==========================================================
  // Line history for edge and condition detection
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else if (clk_en_i) begin
      scl_d <= scl_i;
      sda_d <= sda_i;
    end
  end

  // ==========================================================
  // Bit sequencing: sample on SCL rise, change SDA on SCL fall
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state       <= ST_IDLE;
      shift       <= '0;
      tx          <= '0;
      bitcnt      <= '0;
      rw          <= 1'b0;
      first       <= 1'b0;
      wr_stb_o    <= 1'b0;
      wr_first_o  <= 1'b0;
      wr_data_o   <= '0;
      rd_stb_o    <= 1'b0;
      sda_drive_o <= 1'b0;
    end else if (clk_en_i) begin
      wr_stb_o <= 1'b0;
      rd_stb_o <= 1'b0;
      if (start_c) begin
        // Repeated start also restarts the pointer phase
        state       <= ST_ADDR;
        bitcnt      <= '0;
        first       <= 1'b1;
        sda_drive_o <= 1'b0;
      end else if (stop_c) begin
        state       <= ST_IDLE;
        sda_drive_o <= 1'b0;
      end else if (scl_rise) begin
        case (state)
          ST_ADDR, ST_WRITE: begin
            shift  <= {shift[6:0], sda_i};
            bitcnt <= bitcnt + BIT_ONE;
          end
          ST_READ_ACK: begin
            // Master not-acknowledge ends the read
            if (sda_i) state <= ST_IDLE;
          end
          default: ;
        endcase
      end else if (scl_fall) begin
        case (state)
          ST_ADDR: begin
            if (bitcnt == BYTE_BITS) begin
              if (shift[7:1] == LINK_DEV_ADDR) begin
                state       <= ST_ADDR_ACK;
                sda_drive_o <= 1'b1;
                rw          <= shift[0];
              end else begin
                state <= ST_IDLE;
              end
            end
          end
          ST_WRITE: begin
            if (bitcnt == BYTE_BITS) begin
              wr_stb_o    <= 1'b1;
              wr_data_o   <= shift;
              wr_first_o  <= first;
              first       <= 1'b0;
              sda_drive_o <= 1'b1;
              state       <= ST_WRITE_ACK;
            end
          end
          ST_WRITE_ACK: begin
            sda_drive_o <= 1'b0;
            bitcnt      <= '0;
            state       <= ST_WRITE;
          end
          ST_ADDR_ACK, ST_READ_ACK: begin
            if (rw) begin
              // Load next byte; the bank advances its pointer on rd_stb
              tx          <= {rd_data_i[6:0], 1'b0};
              sda_drive_o <= !rd_data_i[7];
              rd_stb_o    <= 1'b1;
              bitcnt      <= BIT_ONE;
              state       <= ST_READ;
            end else begin
              sda_drive_o <= 1'b0;
              bitcnt      <= '0;
              state       <= ST_WRITE;
            end
          end
          ST_READ: begin
            if (bitcnt == BYTE_BITS) begin
              sda_drive_o <= 1'b0;
              state       <= ST_READ_ACK;
            end else begin
              sda_drive_o <= !tx[7];
              tx          <= {tx[6:0], 1'b0};
              bitcnt      <= bitcnt + BIT_ONE;
            end
          end
          default: ;
        endcase
      end
    end
  end
endmodule : i2c_byte_link

// *** design/sensor_command_irq_regs.sv ***
// Host register set of the light sensor: mailbox, response, flags, results.
// Assumes the measurement sequencer runs on core_clk_i and gives pulses.
// Functional notes
// - Only a mailbox write leaves standby.
// - Each mailbox byte goes to the sequencer; while an error is held, only reset and no-op do.
// - Errors load a response code with MSB set.
// - Error code held until reset, no-op or a newer error.
// - While error held, other commands are ignored.
// - Autonomous measurement reporting continues during an error.
// - No error: low nibble counts finished commands.
// - Unrecognised command gives the invalid-command code.
// - Proximity overflow gives matching channel code.
// - Visible, infrared, auxiliary overflow give their codes.
// - Flag layout: command 5, proximity 4:2, ambient 1:0.
// - Interrupt pin follows any enabled set flag.
// - Policy zero: host writes one to clear.
// - Policy one: auto clear, except mode-11 channels.
// - Visible result low byte first, high next.
// - All registers reset to zero.
// - Parameter inbox carries argument to the sequencer.
// - Infrared high byte follows its low byte.
module sensor_command_irq_regs
  import sensor_regs_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        clk_en_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_n_o,
  input  wire logic        seq_done_i,
  input  wire logic        seq_invalid_i,
  input  wire logic [5:0]  overflow_i,
  input  wire logic [2:0]  prox_event_i,
  input  wire logic [1:0]  ambient_event_field_i,
  input  wire logic        seq_auto_clear_i,
  input  wire logic        standby_i,
  input  wire logic [5:0]  irq_enable_i,
  input  wire logic        clear_policy_i,
  input  wire logic [5:0]  prox_irq_mode_field_i,
  input  wire logic        vis_load_i,
  input  wire logic [15:0] vis_result_i,
  input  wire logic        ir_load_i,
  input  wire logic [15:0] ir_result_i,
  output logic             cmd_valid_o,
  output logic [7:0]       cmd_code_o,
  output logic [7:0]       cmd_arg_o,
  output logic             awake_o,
  output logic             irq_o
);
  // ==========================================================
  // Declarations
  logic [1:0]           pins_sync;      // Synchronised SCL, SDA
  logic                 wr_stb;         // Byte written by host
  logic                 wr_first;       // Byte is the pointer
  logic [7:0]           wr_data;        // Written byte
  logic                 rd_stb;         // Byte handed to the link
  logic                 sda_drive;      // Link pulls SDA low
  logic [7:0]           rd_data;        // Byte at the pointer
  logic [7:0]           ptr;            // Register pointer
  logic [7:0]           command_mailbox;
  logic [7:0]           parameter_inbox;
  logic [7:0]           response_code;
  logic [FLAG_BITS-1:0] pending_flags;  // Reserved bits are not stored
  logic [15:0]          vis_result;
  logic [15:0]          ir_result;
  logic                 host_wr;        // Data byte write
  logic                 mb_wr;          // Mailbox write
  logic                 err_held;       // Response holds an error
  logic                 clear_code;     // Reset or no-op command
  logic                 cmd_pass;       // Command forwarded
  logic                 fault_hit;      // Error event this cycle
  logic [7:0]           fault_code;
  logic [FLAG_BITS-1:0] flag_set;
  logic [FLAG_BITS-1:0] flag_clr;
  logic [FLAG_BITS-1:0] flag_keep;      // Survives auto clear

  // ==========================================================
  // Link front end
  pin_sync #(
    .WIDTH (2)
  ) u_sync (
    .core_clk_i (core_clk_i),
    .arst_n_i   (arst_n_i),
    .clk_en_i   (clk_en_i),
    .pin_i      ({scl_i, sda_i}),
    .sync_o     (pins_sync)
  );

  i2c_byte_link u_link (
    .core_clk_i  (core_clk_i),
    .arst_n_i    (arst_n_i),
    .clk_en_i    (clk_en_i),
    .scl_i       (pins_sync[1]),
    .sda_i       (pins_sync[0]),
    .rd_data_i   (rd_data),
    .wr_stb_o    (wr_stb),
    .wr_first_o  (wr_first),
    .wr_data_o   (wr_data),
    .rd_stb_o    (rd_stb),
    .sda_drive_o (sda_drive)
  );

  // Open-drain pin: output low, enable low while pulling
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= 1'b1;
    end else if (clk_en_i) begin
      sda_o      <= 1'b0;
      sda_oe_n_o <= !sda_drive;
    end
  end

  // ==========================================================
  // Pointer: first write byte loads it, each data byte advances it
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ptr <= REG_RESET;
    end else if (clk_en_i) begin
      if (wr_stb && wr_first) begin
        ptr <= wr_data;
      end else if (host_wr || rd_stb) begin
        ptr <= ptr + 8'h01;
      end
    end
  end

  assign host_wr    = wr_stb && !wr_first;
  assign mb_wr      = host_wr && (ptr == OFS_MAILBOX);
  assign err_held   = response_code[7];
  assign clear_code = (wr_data == CMD_RESET_CODE) || (wr_data == NO_OPERATION_CMD);
  assign cmd_pass   = mb_wr && (!err_held || clear_code);
  assign fault_hit  = seq_invalid_i || (|overflow_i);

  // ==========================================================
  // Read mux; unmapped offsets read zero
  always_comb begin
    case (ptr)
      OFS_PARAM_INBOX: rd_data = parameter_inbox;
      OFS_MAILBOX:     rd_data = command_mailbox;
      OFS_RESPONSE:    rd_data = response_code;
      OFS_FLAGS:       rd_data = {2'b00, pending_flags};
      OFS_VIS_LOW:     rd_data = vis_result[7:0];
      OFS_VIS_HIGH:    rd_data = vis_result[15:8];
      OFS_IR_LOW:      rd_data = ir_result[7:0];
      OFS_IR_HIGH:     rd_data = ir_result[15:8];
      default:         rd_data = REG_RESET;
    endcase
  end

  // ==========================================================
  // Mailbox and argument; a blocked command is still stored
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      command_mailbox <= REG_RESET;
      parameter_inbox <= REG_RESET;
    end else if (clk_en_i) begin
      if (mb_wr) command_mailbox <= wr_data;
      if (host_wr && ptr == OFS_PARAM_INBOX) parameter_inbox <= wr_data;
    end
  end

  // Command hand-off to the sequencer, one-cycle pulse
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cmd_valid_o <= 1'b0;
      cmd_code_o  <= REG_RESET;
      cmd_arg_o   <= REG_RESET;
    end else if (clk_en_i) begin
      cmd_valid_o <= cmd_pass;
      if (cmd_pass) begin
        cmd_code_o <= wr_data;
        cmd_arg_o  <= (ptr == OFS_PARAM_INBOX) ? wr_data : parameter_inbox;
      end
    end
  end

  // Standby exit: no other bus access touches this
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      awake_o <= 1'b0;
    end else if (clk_en_i) begin
      if (mb_wr) begin
        awake_o <= 1'b1;
      end else if (standby_i) begin
        awake_o <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Response: fault codes win over clear, count and host write in the same cycle
  always_comb begin
    if (seq_invalid_i)      fault_code = ERR_INVALID;
    else if (overflow_i[0]) fault_code = ERR_PROX_ONE;
    else if (overflow_i[1]) fault_code = ERR_PROX_TWO;
    else if (overflow_i[2]) fault_code = ERR_PROX_THREE;
    else if (overflow_i[3]) fault_code = ERR_VISIBLE;
    else if (overflow_i[4]) fault_code = ERR_INFRARED;
    else if (overflow_i[5]) fault_code = ERR_AUX;
    else                    fault_code = REG_RESET;
  end

  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      response_code <= REG_RESET;
    end else if (clk_en_i) begin
      if (fault_hit) begin
        response_code <= fault_code;
      end else if (cmd_pass && clear_code) begin
        response_code <= REG_RESET;
      end else if (seq_done_i && !err_held) begin
        response_code <= {4'h0, response_code[3:0] + COUNT_STEP};
      end else if (host_wr && ptr == OFS_RESPONSE && !err_held) begin
        response_code <= wr_data;
      end
    end
  end

  // ==========================================================
  // Event flags; set wins over any clear in the same cycle
  assign flag_set = {seq_done_i, prox_event_i, ambient_event_field_i};
  assign flag_clr = (host_wr && ptr == OFS_FLAGS && !clear_policy_i)
                    ? wr_data[FLAG_BITS-1:0] : '0;

  assign flag_keep[FLAG_PROX_POS-1:0] = '0;
  assign flag_keep[FLAG_CMD_POS]      = 1'b0;
  for (genvar ch = 0; ch < PROX_CHANNELS; ch++) begin : g_keep
    assign flag_keep[FLAG_PROX_POS+ch] =
      (prox_irq_mode_field_i[2*ch +: 2] == PROX_MODE_KEEP);
  end

  for (genvar b = 0; b < FLAG_BITS; b++) begin : g_flag
    // Measurement events still land while an error is held
    always_ff @(posedge core_clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
        pending_flags[b] <= 1'b0;
      end else if (clk_en_i) begin
        if (flag_set[b]) begin
          pending_flags[b] <= 1'b1;
        end else if (flag_clr[b]) begin
          pending_flags[b] <= 1'b0;
        end else if (clear_policy_i && seq_auto_clear_i && !flag_keep[b]) begin
          pending_flags[b] <= 1'b0;
        end
      end
    end
  end

  // Interrupt pin, one cycle behind the flags
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else if (clk_en_i) begin
      irq_o <= |(pending_flags & irq_enable_i);
    end
  end

  // ==========================================================
  // Results: sequencer loads win over host writes
  always_ff @(posedge core_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      vis_result <= '0;
      ir_result  <= '0;
    end else if (clk_en_i) begin
      if (vis_load_i) vis_result <= vis_result_i;
      else if (host_wr && ptr == OFS_VIS_LOW) vis_result[7:0] <= wr_data;
      else if (host_wr && ptr == OFS_VIS_HIGH) vis_result[15:8] <= wr_data;
      if (ir_load_i) ir_result <= ir_result_i;
      else if (host_wr && ptr == OFS_IR_LOW) ir_result[7:0] <= wr_data;
      else if (host_wr && ptr == OFS_IR_HIGH) ir_result[15:8] <= wr_data;
    end
  end

  // ==========================================================
  // Checks
  default clocking cb @(posedge core_clk_i iff clk_en_i); endclocking
  default disable iff (!arst_n_i);

  sequence blocked_write_s;
    err_held && mb_wr && !clear_code && !fault_hit;
  endsequence

  sequence quiet_error_s;
    err_held && !fault_hit && !(cmd_pass && clear_code);
  endsequence

  wake_by_mailbox_a: assert property ($rose(awake_o) |-> $past(mb_wr))
    else $error("standby left without a mailbox write");
  cmd_forward_a: assert property (mb_wr && !err_held |=> cmd_valid_o && cmd_code_o == $past(wr_data))
    else $error("mailbox byte not handed to sequencer");
  error_msb_set_a: assert property (fault_hit |=> response_code[7])
    else $error("error code without top bit");
  error_hold_a: assert property (quiet_error_s |=> response_code == $past(response_code))
    else $error("held error code changed");
  blocked_cmd_a: assert property (blocked_write_s |=> !cmd_valid_o)
    else $error("command passed while error held");
  counter_step_a: assert property (seq_done_i && !err_held && !fault_hit && !cmd_pass
                                   |=> response_code == {4'h0, $past(response_code[3:0]) + COUNT_STEP})
    else $error("completion counter did not step");
  invalid_code_a: assert property (seq_invalid_i |=> response_code == ERR_INVALID)
    else $error("invalid-command code missing");
  prox_overflow_a: assert property (overflow_i == 6'h02 && !seq_invalid_i |=> response_code == ERR_PROX_TWO)
    else $error("proximity overflow code wrong");
  aux_overflow_a: assert property (overflow_i == 6'h20 && !seq_invalid_i |=> response_code == ERR_AUX)
    else $error("auxiliary overflow code wrong");
  irq_follow_a: assert property (##1 irq_o == $past(|(pending_flags & irq_enable_i)))
    else $error("interrupt pin does not follow flags");
  flag_w1c_a: assert property (flag_clr[FLAG_CMD_POS] && !seq_done_i |=> !pending_flags[FLAG_CMD_POS])
    else $error("command flag not cleared by host");
  keep_sticky_a: assert property (clear_policy_i && seq_auto_clear_i && flag_keep[FLAG_PROX_POS]
                                  && pending_flags[FLAG_PROX_POS] && flag_clr[FLAG_PROX_POS] == 1'b0
                                  |=> pending_flags[FLAG_PROX_POS])
    else $error("mode-11 flag lost on auto clear");
endmodule : sensor_command_irq_regs

// *** test/i2c_host_model.sv ***
// I2C host model: single-byte register writes and reads.
// Assumes the bench resolves SDA with a pull-up and feeds it back.
module i2c_host_model
  import sensor_regs_pkg::*;
(
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic nack = 1'h0;  // Sticky missed acknowledge
  // Idle bus: both lines released, SCL stands high
  initial begin
    scl_o = 1'h1;
    sda_o = 1'h1;
  end
  task automatic tk(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : tk
  // One 400 ns bit, sampled mid high phase
  task automatic bt(input logic v, output logic s);
    sda_o = v;
    tk(2);
    scl_o = 1'h1;
    tk(2);
    s = sda_i;
    tk(2);
    scl_o = 1'h0;
    tk(2);
  endtask : bt
  task automatic st;
    sda_o = 1'h1;
    tk(2);
    scl_o = 1'h1;
    tk(4);
    sda_o = 1'h0;
    tk(4);
    scl_o = 1'h0;
    tk(2);
  endtask : st
  task automatic sp;
    sda_o = 1'h0;
    tk(2);
    scl_o = 1'h1;
    tk(4);
    sda_o = 1'h1;
    tk(4);
  endtask : sp
  // Byte plus ninth bit; a write expects the device to pull low
  task automatic xb(input logic [7:0] b, input logic w, output logic [7:0] r);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bt(b[i], s);
      r[i] = s;
    end
    bt(1'h1, s);
    if (w && s !== 1'h0) nack = 1'h1;
  endtask : xb
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    st;
    xb({LINK_DEV_ADDR, 1'h0}, 1'h1, r);
    xb(a, 1'h1, r);
    xb(d, 1'h1, r);
    sp;
  endtask : wr
  // Pointer write, repeated start, one byte read ended by NACK
  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    st;
    xb({LINK_DEV_ADDR, 1'h0}, 1'h1, r);
    xb(a, 1'h1, r);
    st;
    xb({LINK_DEV_ADDR, 1'h1}, 1'h1, r);
    xb(8'hFF, 1'h0, r);
    sp;
  endtask : rd
endmodule : i2c_host_model

// *** test/tb_top.sv ***
// Self-checking bench of the sensor register set.
// Assumes SDA has a pull-up; the host model drives SCL.
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import sensor_regs_pkg::*;
  logic clk = 0, rst_n = 0, scl, sda_m, sda_d, sda_oe_n, valid, awake, irq;
  logic en = 1, sby = 0;  // Clock enable and standby pulse, both exercised
  logic [1:0] amb = 0;    // Ambient event pulses
  logic done = 0, inv = 0, acl = 0, pol = 0, vld = 0, ild = 0;
  logic [5:0] ovf = 0, ien = 6'h3F, mode = 0;
  logic [2:0] prx = 0;
  logic [15:0] vis = 0, ir = 0;
  logic [7:0] code, arg, r, fc, fa, b, c, fwd = 0;
  logic [7:0] errs [7] = '{ERR_PROX_ONE, ERR_PROX_TWO, ERR_PROX_THREE, ERR_VISIBLE, ERR_INFRARED, ERR_AUX, ERR_INVALID};
  int err_count = 0, cmp_count = 0, seed;
  wire sda = sda_m & (sda_oe_n | sda_d);  // Open drain with pull-up
  always #25 clk = ~clk;
  sensor_command_irq_regs u_sensor_command_irq_regs (.core_clk_i(clk), .arst_n_i(rst_n), .clk_en_i(en),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_d), .sda_oe_n_o(sda_oe_n), .seq_done_i(done), .seq_invalid_i(inv),
    .overflow_i(ovf), .prox_event_i(prx), .ambient_event_field_i(amb), .seq_auto_clear_i(acl),
    .standby_i(sby), .irq_enable_i(ien), .clear_policy_i(pol), .prox_irq_mode_field_i(mode),
    .vis_load_i(vld), .vis_result_i(vis), .ir_load_i(ild), .ir_result_i(ir), .cmd_valid_o(valid),
    .cmd_code_o(code), .cmd_arg_o(arg), .awake_o(awake), .irq_o(irq));
  i2c_host_model host (.clk_i(clk), .sda_i(sda), .scl_o(scl), .sda_o(sda_m));
  // Count forwarded commands and keep the last one
  always @(posedge clk) if (valid === 1'h1) begin
    fwd <= fwd + 8'h01;
    fc <= code;
    fa <= arg;
  end
  task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
    cmp_count++;
    if (s !== e) begin
      err_count++;
      $display("CHECK FAILED %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    host.rd(a, r);
    chk($sformatf("reg %h", a), r, e);
  endtask : rc
  task automatic tally_and_finish;
    $display("errors %0d checks %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : tally_and_finish
  initial begin
    #2000000;
    err_count++;
    tally_and_finish;
  end
  initial begin
    seed = 96;
    repeat (16) @(posedge clk);
    #1 rst_n = 1;
    host.tk(4);
    for (int a = 32; a < 38; a++) rc(a[7:0], 8'h00);
    b = 8'($random(seed));
    c = 8'($random(seed));
    host.wr(OFS_PARAM_INBOX, b);
    chk("awake", 8'(awake), 8'h00);
    host.wr(OFS_MAILBOX, c);
    chk("fwd", fwd, 8'h01);
    chk("code", fc, c);
    chk("arg", fa, b);
    chk("awake", 8'(awake), 8'h01);
    done = 1; prx = 3'h5; host.tk(1); done = 0; prx = 0; host.tk(2);
    chk("irq", 8'(irq), 8'h01);
    rc(OFS_RESPONSE, 8'h01);
    rc(OFS_FLAGS, 8'h34);
    host.wr(OFS_FLAGS, 8'hE4);
    rc(OFS_FLAGS, 8'h10);
    ien = 6'h0F; host.tk(2);
    chk("irq", 8'(irq), 8'h00);
    host.wr(OFS_FLAGS, 8'h10);
    pol = 1; mode = 6'h03; prx = 3'h3; host.tk(1); prx = 0; acl = 1; host.tk(1); acl = 0;
    rc(OFS_FLAGS, 8'h04);
    pol = 0;
    host.wr(OFS_FLAGS, 8'h04);
    for (int k = 0; k < 7; k++) begin
      if (k < 6) ovf[k] = 1'h1; else inv = 1;
      host.tk(1); ovf = 0; inv = 0;
      rc(OFS_RESPONSE, errs[k]);
    end
    host.wr(OFS_MAILBOX, 8'h07);
    done = 1; host.tk(1); done = 0;
    chk("fwd", fwd, 8'h01);
    rc(OFS_RESPONSE, ERR_INVALID);
    vis = 16'($random(seed)); ir = 16'($random(seed)); vld = 1; ild = 1; host.tk(1); vld = 0; ild = 0;
    rc(OFS_VIS_LOW, vis[7:0]);
    rc(OFS_VIS_HIGH, vis[15:8]);
    rc(OFS_IR_LOW, ir[7:0]);
    rc(OFS_IR_HIGH, ir[15:8]);
    host.wr(OFS_MAILBOX, CMD_RESET_CODE);
    chk("fwd", fwd, 8'h02);
    rc(OFS_RESPONSE, 8'h00);
    // Frozen clock: a completion pulse must not step the counter
    en = 0;
    done = 1;
    host.tk(2);
    done = 0;
    host.tk(1);
    en = 1;
    rc(OFS_RESPONSE, 8'h00);
    amb = 2'h3;
    host.tk(1);
    amb = 0;
    rc(OFS_FLAGS, 8'h23);
    chk("irq", 8'(irq), 8'h01);
    // Back to standby; only a mailbox write may wake it again
    sby = 1;
    host.tk(1);
    sby = 0;
    host.wr(OFS_PARAM_INBOX, c);
    rc(OFS_MAILBOX, CMD_RESET_CODE);
    chk("awake", 8'(awake), 8'h00);
    // Second reset in mid-run: written registers must return to zero
    rst_n = 0;
    host.tk(2);
    rst_n = 1;
    host.tk(4);
    chk("irq", 8'(irq), 8'h00);
    rc(OFS_PARAM_INBOX, 8'h00);
    rc(OFS_MAILBOX, 8'h00);
    rc(OFS_FLAGS, 8'h00);
    rc(OFS_VIS_HIGH, 8'h00);
    chk("nack", 8'(host.nack), 8'h00);
    tally_and_finish;
  end
endmodule : tb_top
